//--- inc/apsl_pkg.sv
// constants shared by the panel scan, load and option control block
// assumes a single 200 MHz clock and word-wide AHB-Lite register access
package apsl_pkg;

    localparam int CLK_KHZ        = 200000;
    localparam int PHASE_HIGH_MS  = 2;
    localparam int PHASE_SLOT_MS  = 10;
    // exact multiples of the clock period, so no rounding is involved
    localparam int PHASE_HIGH_CYC = PHASE_HIGH_MS * CLK_KHZ;
    localparam int PHASE_SLOT_CYC = PHASE_SLOT_MS * CLK_KHZ;

    localparam int SCAN_PHASES = 5;
    localparam int KEY_LINES   = 2;
    localparam int NUM_KEYS    = SCAN_PHASES * KEY_LINES;
    localparam int STRAP_W     = 40;
    localparam int CNT_W       = 22;

    // register byte offsets
    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_STATUS  = 5'h04;
    localparam logic [4:0] REG_KEYEVT  = 5'h08;
    localparam logic [4:0] REG_OPTLO   = 5'h0c;
    localparam logic [4:0] REG_OPTHI   = 5'h10;
    localparam logic [4:0] REG_DECODE0 = 5'h14;
    localparam logic [4:0] REG_DECODE1 = 5'h18;

    // control fields
    localparam int CTRL_COMP_REQ = 0;
    localparam int CTRL_FDEF_REQ = 1;
    localparam int CTRL_RDEF_REQ = 2;
    localparam int CTRL_FFAN_REQ = 3;
    localparam int CTRL_RFAN_REQ = 4;
    localparam int CTRL_AMB_LOW  = 5;
    localparam int CTRL_W        = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

    // status fields
    localparam int ST_COMP      = 0;
    localparam int ST_FDEF      = 1;
    localparam int ST_RDEF      = 2;
    localparam int ST_FFAN      = 3;
    localparam int ST_RFAN      = 4;
    localparam int ST_FDOOR     = 5;
    localparam int ST_RDOOR     = 6;
    localparam int ST_OPT_VALID = 7;
    localparam int ST_PHASE_LSB = 8;
    localparam int ST_FSET_LSB  = 12;

    // strap field positions
    localparam int FZ_OFS_LSB   = 0;
    localparam int FR_OFS_LSB   = 3;
    localparam int FR_OFS_SIGN  = 6;
    localparam int FZ_COLD_LSB  = 7;
    localparam int FR_COLD_LSB  = 9;
    localparam int FZ_WARM_LSB  = 11;
    localparam int LOW_COMP_LSB = 13;

    // decoded values are signed, in half degrees; index is the field value
    localparam logic [3:0][7:0] FZ_COLD_TBL  = {8'h0a, 8'h08, 8'h06, 8'h04};
    localparam logic [3:0][7:0] FR_COLD_TBL  = {8'h04, 8'h0a, 8'h06, 8'h08};
    localparam logic [3:0][7:0] FZ_WARM_TBL  = {8'h0a, 8'h06, 8'h04, 8'h08};
    localparam logic [3:0][7:0] LOW_COMP_TBL = {8'h00, 8'h01, 8'hfe, 8'hff};

    localparam logic [2:0] FRZ_SET_MAX  = 3'h4;
    localparam logic [2:0] FRZ_SET_RST  = 3'h2;
    localparam logic [1:0] SYNC_SETTLE  = 2'h2;

    typedef enum logic {
        OPT_WAIT = 1'b0,
        OPT_HELD = 1'b1
    } apsl_opt_st_e;

endpackage : apsl_pkg

//--- inc/apsl_core_if.sv
// carries scan results and decoded options from the two leaf modules to the top
// assumes all three modules share mclk
`timescale 1ns/1ps
interface apsl_core_if;
    logic [2:0]                      phaseIdx;
    logic                            keyStrobe;
    logic [apsl_pkg::KEY_LINES-1:0]  keySample;
    logic [apsl_pkg::STRAP_W-1:0]    strapHeld;
    logic                            optValid;
    logic [7:0]                      frzOffset;
    logic [7:0]                      frOffset;
    logic [7:0]                      frzColder;
    logic [7:0]                      frColder;
    logic [7:0]                      frzWarmer;
    logic [7:0]                      lowComp;

    modport scan (output phaseIdx, keyStrobe, keySample);
    modport opt  (output strapHeld, optValid, frzOffset, frOffset, frzColder, frColder, frzWarmer, lowComp);
    modport core (input  phaseIdx, keyStrobe, keySample, strapHeld, optValid,
                  frzOffset, frOffset, frzColder, frColder, frzWarmer, lowComp);
endinterface : apsl_core_if

//--- src/apsl_scan.sv
// scan phase generator and key sense sampler
// assumes key sense pins are asynchronous to mclk
`timescale 1ns/1ps
module apsl_scan #(
    parameter int PHASE_HIGH_CYC = apsl_pkg::PHASE_HIGH_CYC,
    parameter int PHASE_SLOT_CYC = apsl_pkg::PHASE_SLOT_CYC
) (
    input  wire logic                                 mclk,
    input  wire logic                                 rst,
    input  wire logic [apsl_pkg::KEY_LINES-1:0]       keySense,
    output logic      [apsl_pkg::SCAN_PHASES-1:0]     phaseLine,
    apsl_core_if.scan                                 cif
);
    localparam logic [apsl_pkg::CNT_W-1:0] HIGH_LAST = apsl_pkg::CNT_W'(PHASE_HIGH_CYC - 1);
    localparam logic [apsl_pkg::CNT_W-1:0] SLOT_LAST = apsl_pkg::CNT_W'(PHASE_SLOT_CYC - 1);
    localparam logic [2:0]                 IDX_LAST  = 3'(apsl_pkg::SCAN_PHASES - 1);

    logic [apsl_pkg::CNT_W-1:0]       cnt_q, cnt_d;
    logic [2:0]                       idx_q, idx_d;
    logic [apsl_pkg::SCAN_PHASES-1:0] line_q, line_d;
    logic [apsl_pkg::KEY_LINES-1:0]   senseMeta_q, senseSync_q;
    logic                             strobe_q, strobe_d;
    logic [apsl_pkg::KEY_LINES-1:0]   sample_q, sample_d;

    always_comb begin
        cnt_d    = (cnt_q == SLOT_LAST) ? '0 : cnt_q + 1'b1;
        idx_d    = idx_q;
        if (cnt_q == SLOT_LAST) begin
            idx_d = (idx_q == IDX_LAST) ? 3'h0 : idx_q + 3'h1;
        end
        line_d   = '0;
        if (cnt_d <= HIGH_LAST) begin
            line_d[idx_d] = 1'b1;
        end
        // sample at the end of the pulse, when the key path has settled
        strobe_d = (cnt_q == HIGH_LAST);
        sample_d = strobe_d ? senseSync_q : sample_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q       <= SLOT_LAST; // wraps on the first edge so the first pulse is full width
            idx_q       <= IDX_LAST;
            line_q      <= '0;
            senseMeta_q <= '0;
            senseSync_q <= '0;
            strobe_q    <= 1'b0;
            sample_q    <= '0;
        end else begin
            cnt_q       <= cnt_d;
            idx_q       <= idx_d;
            line_q      <= line_d;
            senseMeta_q <= keySense;
            senseSync_q <= senseMeta_q;
            strobe_q    <= strobe_d;
            sample_q    <= sample_d;
        end
    end

    assign phaseLine     = line_q;
    assign cif.phaseIdx  = idx_q;
    assign cif.keyStrobe = strobe_q;
    assign cif.keySample = sample_q;
endmodule : apsl_scan

//--- src/apsl_opt.sv
// option strap capture and decode
// assumes strap pins are static but asynchronous; captured once per reset
`timescale 1ns/1ps
module apsl_opt (
    input  wire logic                            mclk,
    input  wire logic                            rst,
    input  wire logic [apsl_pkg::STRAP_W-1:0]    strap,
    apsl_core_if.opt                             cif
);
    logic [apsl_pkg::STRAP_W-1:0] meta_q, sync_q;
    logic [apsl_pkg::STRAP_W-1:0] held_q, held_d;
    logic [1:0]                   wait_q, wait_d;
    apsl_pkg::apsl_opt_st_e       st_q, st_d;
    logic [2:0]                   fzN;
    logic [2:0]                   frN;

    always_comb begin
        st_d   = st_q;
        wait_d = wait_q;
        held_d = held_q;
        case (st_q)
            apsl_pkg::OPT_WAIT: begin
                // let the synchroniser fill before trusting the straps
                if (wait_q == apsl_pkg::SYNC_SETTLE) begin
                    held_d = sync_q;
                    st_d   = apsl_pkg::OPT_HELD;
                end else begin
                    wait_d = wait_q + 2'h1;
                end
            end
            apsl_pkg::OPT_HELD: begin
                held_d = held_q;
            end
            default: begin
                st_d = apsl_pkg::OPT_WAIT;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
            held_q <= '0;
            wait_q <= 2'h0;
            st_q   <= apsl_pkg::OPT_WAIT;
        end else begin
            meta_q <= strap;
            sync_q <= meta_q;
            held_q <= held_d;
            wait_q <= wait_d;
            st_q   <= st_d;
        end
    end

    assign fzN = held_q[apsl_pkg::FZ_OFS_LSB +: 3];
    assign frN = held_q[apsl_pkg::FR_OFS_LSB +: 3];

    assign cif.strapHeld = held_q;
    assign cif.optValid  = (st_q == apsl_pkg::OPT_HELD);
    assign cif.frzOffset = 8'h00 - {5'h00, fzN};
    assign cif.frOffset  = held_q[apsl_pkg::FR_OFS_SIGN] ? {5'h00, frN} + 8'h01
                                                         : 8'h00 - {5'h00, frN};
    assign cif.frzColder = apsl_pkg::FZ_COLD_TBL[held_q[apsl_pkg::FZ_COLD_LSB +: 2]];
    assign cif.frColder  = apsl_pkg::FR_COLD_TBL[held_q[apsl_pkg::FR_COLD_LSB +: 2]];
    assign cif.frzWarmer = apsl_pkg::FZ_WARM_TBL[held_q[apsl_pkg::FZ_WARM_LSB +: 2]];
    assign cif.lowComp   = apsl_pkg::LOW_COMP_TBL[held_q[apsl_pkg::LOW_COMP_LSB +: 2]];
endmodule : apsl_opt

//--- src/apsl_ctrl.sv
// top of the panel scan, load interlock and option block with its AHB-Lite slave
// assumes single word transfers, one 200 MHz clock and pins asynchronous to it
//
// Contract
// - phases high in turn, 2ms every 10ms
// - sense pulse during phase means that key pressed
// - compressor drive high runs the compressor
// - no requests keep compressor and heaters off
// - compressor on forces both defrost heaters off
// - freezer defrost on forces compressor off
// - read forty option straps, fitted reads one
// - strap changes apply only after power cycle
// - freezer offset lowers target by half degrees
// - fridge offset signed, minus n or plus n+1
// - freezer colder gap table 2,3,4,5
// - fridge colder gap table 4,3,5,2
// - freezer warmer gap table 4,2,3,5
// - low ambient compensation selected by two bits
// - open door reads low and stops fan
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module apsl_ctrl #(
    parameter int PHASE_HIGH_CYC = apsl_pkg::PHASE_HIGH_CYC,
    parameter int PHASE_SLOT_CYC = apsl_pkg::PHASE_SLOT_CYC
) (
    input  wire logic                                mclk,
    input  wire logic                                rst,
    input  wire logic                                hsel,
    input  wire logic [31:0]                         haddr,
    input  wire logic [1:0]                          htrans,
    input  wire logic                                hwrite,
    input  wire logic [2:0]                          hsize,
    input  wire logic [31:0]                         hwdata,
    input  wire logic                                hready,
    output logic      [31:0]                         hrdata,
    output logic                                     hreadyout,
    output logic                                     hresp,
    input  wire logic [apsl_pkg::KEY_LINES-1:0]      keySense,
    input  wire logic [apsl_pkg::STRAP_W-1:0]        strap,
    input  wire logic                                freezerDoorContact,
    input  wire logic                                fridgeDoorContact,
    output logic      [apsl_pkg::SCAN_PHASES-1:0]    scanPhaseLine,
    output logic                                     compDrive,
    output logic                                     freezerDefrostDrive,
    output logic                                     fridgeDefrostDrive,
    output logic                                     freezerFanDrive,
    output logic                                     fridgeFanDrive
);
    apsl_core_if cif ();

    apsl_scan #(
        .PHASE_HIGH_CYC (PHASE_HIGH_CYC),
        .PHASE_SLOT_CYC (PHASE_SLOT_CYC)
    ) u_scan (
        .mclk      (mclk),
        .rst       (rst),
        .keySense  (keySense),
        .phaseLine (scanPhaseLine),
        .cif       (cif.scan)
    );

    apsl_opt u_opt (
        .mclk  (mclk),
        .rst   (rst),
        .strap (strap),
        .cif   (cif.opt)
    );

    // ---------------- bus slave ----------------
    logic                           wrPend_q, wrPend_d;
    logic [4:0]                     wrAddr_q, wrAddr_d;
    logic [31:0]                    rdata_q, rdata_d;
    logic                           ready_q;
    logic                           addrPhase;
    logic                           wrKey;
    logic                           wrCtrl;
    logic [31:0]                    rdMux;
    logic [apsl_pkg::CTRL_W-1:0]    ctrl_q, ctrl_d;

    // ---------------- load and door state ----------------
    logic                           comp_q, comp_d;
    logic                           fDef_q, fDef_d;
    logic                           rDef_q, rDef_d;
    logic                           fFan_q, fFan_d;
    logic                           rFan_q, rFan_d;
    logic                           fDoorMeta_q, fDoorSync_q;
    logic                           rDoorMeta_q, rDoorSync_q;

    // ---------------- key state ----------------
    logic [apsl_pkg::NUM_KEYS-1:0]  keyLvl_q, keyLvl_d;
    logic [apsl_pkg::NUM_KEYS-1:0]  keyEvt_q, keyEvt_d;
    logic [apsl_pkg::NUM_KEYS-1:0]  keySet;
    logic [2:0]                     fSet_q, fSet_d;

    // ---------------- effective option values ----------------
    logic [7:0]                     comp8;
    logic [7:0]                     frzEff;
    logic [7:0]                     frEff;

    assign addrPhase = hsel & htrans[1] & hready;
    assign wrCtrl    = wrPend_q & (wrAddr_q == apsl_pkg::REG_CTRL);
    assign wrKey     = wrPend_q & (wrAddr_q == apsl_pkg::REG_KEYEVT);

    // compensation only counts while software reports a cold room
    assign comp8  = ctrl_q[apsl_pkg::CTRL_AMB_LOW] ? cif.lowComp : 8'h00;
    assign frzEff = cif.frzOffset + comp8;
    assign frEff  = cif.frOffset + comp8;

    always_comb begin
        rdMux = 32'h0000_0000;
        case (haddr[4:0])
            apsl_pkg::REG_CTRL: begin
                rdMux[apsl_pkg::CTRL_W-1:0] = ctrl_q;
            end
            apsl_pkg::REG_STATUS: begin
                rdMux[apsl_pkg::ST_COMP]                = comp_q;
                rdMux[apsl_pkg::ST_FDEF]                = fDef_q;
                rdMux[apsl_pkg::ST_RDEF]                = rDef_q;
                rdMux[apsl_pkg::ST_FFAN]                = fFan_q;
                rdMux[apsl_pkg::ST_RFAN]                = rFan_q;
                rdMux[apsl_pkg::ST_FDOOR]               = fDoorSync_q;
                rdMux[apsl_pkg::ST_RDOOR]               = rDoorSync_q;
                rdMux[apsl_pkg::ST_OPT_VALID]           = cif.optValid;
                rdMux[apsl_pkg::ST_PHASE_LSB +: 3]      = cif.phaseIdx;
                rdMux[apsl_pkg::ST_FSET_LSB +: 3]       = fSet_q;
            end
            apsl_pkg::REG_KEYEVT: begin
                rdMux[apsl_pkg::NUM_KEYS-1:0] = keyEvt_q;
            end
            apsl_pkg::REG_OPTLO: begin
                rdMux = cif.strapHeld[31:0];
            end
            apsl_pkg::REG_OPTHI: begin
                rdMux[7:0] = cif.strapHeld[apsl_pkg::STRAP_W-1:32];
            end
            apsl_pkg::REG_DECODE0: begin
                rdMux[23:0] = {comp8, frEff, frzEff};
            end
            apsl_pkg::REG_DECODE1: begin
                rdMux[23:0] = {cif.frzWarmer, cif.frColder, cif.frzColder};
            end
            default: begin
                rdMux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        wrPend_d = addrPhase & hwrite;
        wrAddr_d = addrPhase ? haddr[4:0] : wrAddr_q;
        rdata_d  = (addrPhase & ~hwrite) ? rdMux : rdata_q;
        ctrl_d   = wrCtrl ? hwdata[apsl_pkg::CTRL_W-1:0] : ctrl_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 5'h00;
            rdata_q  <= 32'h0000_0000;
            ready_q  <= 1'b1;
            ctrl_q   <= apsl_pkg::CTRL_RST;
        end else begin
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
            rdata_q  <= rdata_d;
            ready_q  <= 1'b1;
            ctrl_q   <= ctrl_d;
        end
    end

    // ---------------- load interlock ----------------
    always_comb begin
        // break before make: a drive only rises once its opponent is seen low
        comp_d = ctrl_q[apsl_pkg::CTRL_COMP_REQ] & ~fDef_q & ~rDef_q;
        fDef_d = ctrl_q[apsl_pkg::CTRL_FDEF_REQ] & ~ctrl_q[apsl_pkg::CTRL_COMP_REQ] & ~comp_q;
        rDef_d = ctrl_q[apsl_pkg::CTRL_RDEF_REQ] & ~ctrl_q[apsl_pkg::CTRL_COMP_REQ] & ~comp_q;
        fFan_d = ctrl_q[apsl_pkg::CTRL_FFAN_REQ] & fDoorSync_q;
        rFan_d = ctrl_q[apsl_pkg::CTRL_RFAN_REQ] & rDoorSync_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            comp_q      <= 1'b0;
            fDef_q      <= 1'b0;
            rDef_q      <= 1'b0;
            fFan_q      <= 1'b0;
            rFan_q      <= 1'b0;
            fDoorMeta_q <= 1'b0;
            fDoorSync_q <= 1'b0;
            rDoorMeta_q <= 1'b0;
            rDoorSync_q <= 1'b0;
        end else begin
            comp_q      <= comp_d;
            fDef_q      <= fDef_d;
            rDef_q      <= rDef_d;
            fFan_q      <= fFan_d;
            rFan_q      <= rFan_d;
            fDoorMeta_q <= freezerDoorContact;
            fDoorSync_q <= fDoorMeta_q;
            rDoorMeta_q <= fridgeDoorContact;
            rDoorSync_q <= rDoorMeta_q;
        end
    end

    // ---------------- keys ----------------
    // key index is phase * lines + line; key 0 is the freezer setting key
    genvar gk;
    generate
        for (gk = 0; gk < apsl_pkg::NUM_KEYS; gk++) begin : g_key
            localparam logic [2:0] KPH = 3'(gk / apsl_pkg::KEY_LINES);
            localparam int         KLN = gk % apsl_pkg::KEY_LINES;
            always_comb begin
                keyLvl_d[gk] = keyLvl_q[gk];
                if (cif.keyStrobe && (cif.phaseIdx == KPH)) begin
                    keyLvl_d[gk] = cif.keySample[KLN];
                end
                keySet[gk]   = keyLvl_d[gk] & ~keyLvl_q[gk];
                // a press landing on the clearing write still sets the flag
                keyEvt_d[gk] = (keyEvt_q[gk] & ~(wrKey & hwdata[gk])) | keySet[gk];
            end
        end
    endgenerate

    always_comb begin
        fSet_d = fSet_q;
        if (keySet[0]) begin
            fSet_d = (fSet_q == apsl_pkg::FRZ_SET_MAX) ? 3'h0 : fSet_q + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            keyLvl_q <= '0;
            keyEvt_q <= '0;
            fSet_q   <= apsl_pkg::FRZ_SET_RST;
        end else begin
            keyLvl_q <= keyLvl_d;
            keyEvt_q <= keyEvt_d;
            fSet_q   <= fSet_d;
        end
    end

    assign hrdata              = rdata_q;
    assign hreadyout           = ready_q;
    assign hresp               = 1'b0;
    assign compDrive           = comp_q;
    assign freezerDefrostDrive = fDef_q;
    assign fridgeDefrostDrive  = rDef_q;
    assign freezerFanDrive     = fFan_q;
    assign fridgeFanDrive      = rFan_q;
endmodule : apsl_ctrl

//--- sim/apsl_panel_model.sv
// panel key matrix model: closes the keys set in pressMask
// assumes the device scans with its phase lines; a sense line with no closed key sits at the pull-down level
`timescale 1ns/1ps
module apsl_panel_model (
    input  wire logic [4:0] phaseLine,
    input  wire logic [9:0] pressMask,
    output logic      [1:0] keySense
);
    // a closed key only passes its own phase pulse back, so sense is never high outside a pulse
    always_comb begin
        keySense = 2'h0;
        for (int k = 0; k < 5; k++) begin
            keySense[0] = keySense[0] | (phaseLine[k] & pressMask[2*k]);
            keySense[1] = keySense[1] | (phaseLine[k] & pressMask[2*k+1]);
        end
    end
endmodule : apsl_panel_model

//--- sim/apsl_ctrl_asserts.sv
// assertion checker for scan timing, load interlock, fans and bus response of apsl_ctrl
// assumes it is bound into apsl_ctrl and sees only its ports
`timescale 1ns/1ps
module apsl_ctrl_asserts #(
    parameter int PHASE_HIGH_CYC = 4,
    parameter int PHASE_SLOT_CYC = 20
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       freezerDoorContact,
    input wire logic       fridgeDoorContact,
    input wire logic [4:0] scanPhaseLine,
    input wire logic       compDrive,
    input wire logic       freezerDefrostDrive,
    input wire logic       fridgeDefrostDrive,
    input wire logic       freezerFanDrive,
    input wire logic       fridgeFanDrive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [4:0] prevLine_q;
    logic [4:0] lastOn_q;
    int         since_q;
    logic       seen_q;
    logic       riseNow;
    // cycles since the last pulse start; width and slot length are both read off it
    assign riseNow = (scanPhaseLine != 5'h00) && (prevLine_q == 5'h00);
    always_ff @(posedge mclk) begin
        if (rst) begin
            prevLine_q <= 5'h00;
            lastOn_q   <= 5'h00;
            since_q    <= 0;
            seen_q     <= 1'b0;
        end else begin
            prevLine_q <= scanPhaseLine;
            since_q    <= riseNow ? 1 : since_q + 1;
            lastOn_q   <= riseNow ? scanPhaseLine : lastOn_q;
            seen_q     <= seen_q | riseNow;
        end
    end
    sequence fzOpen; !freezerDoorContact [*5]; endsequence
    sequence frOpen; !fridgeDoorContact [*5]; endsequence
    phase_onehot_a: assert property ($onehot0(scanPhaseLine))
        else $error("two scan phases high");
    pulse_width_a: assert property (scanPhaseLine == 5'h00 && prevLine_q != 5'h00 |-> since_q == PHASE_HIGH_CYC)
        else $error("scan pulse width wrong");
    slot_len_a: assert property (riseNow && seen_q |-> since_q == PHASE_SLOT_CYC)
        else $error("scan slot length wrong");
    slot_bound_a: assert property (since_q <= PHASE_SLOT_CYC)
        else $error("scan pulse overdue");
    phase_order_a: assert property (riseNow |-> scanPhaseLine == (seen_q ? {lastOn_q[3:0], lastOn_q[4]} : 5'h01))
        else $error("scan phase out of order");
    comp_heat_a: assert property (compDrive |-> !freezerDefrostDrive && !fridgeDefrostDrive)
        else $error("heater on with compressor");
    fdef_comp_a: assert property ($rose(compDrive) |-> !$past(freezerDefrostDrive))
        else $error("compressor started under freezer heater");
    fz_fan_door_a: assert property (fzOpen |-> !freezerFanDrive)
        else $error("freezer fan runs with door open");
    fr_fan_door_a: assert property (frOpen |-> !fridgeFanDrive)
        else $error("fridge fan runs with door open");
    bus_ok_a: assert property (hreadyout && !hresp)
        else $error("bus response not ready okay");
endmodule : apsl_ctrl_asserts

bind apsl_ctrl apsl_ctrl_asserts #(.PHASE_HIGH_CYC(PHASE_HIGH_CYC), .PHASE_SLOT_CYC(PHASE_SLOT_CYC)) apsl_ctrl_asserts_inst (
    .mclk(mclk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .freezerDoorContact(freezerDoorContact),
    .fridgeDoorContact(fridgeDoorContact), .scanPhaseLine(scanPhaseLine), .compDrive(compDrive),
    .freezerDefrostDrive(freezerDefrostDrive), .fridgeDefrostDrive(fridgeDefrostDrive),
    .freezerFanDrive(freezerFanDrive), .fridgeFanDrive(fridgeFanDrive));

//--- sim/apsl_ctrl_tb.sv
// self-checking bench for apsl_ctrl: AHB-Lite register tasks, strap decode, interlock, doors and keys
// assumes short scan counts (4 and 20 cycles) and a zero-wait slave
`timescale 1ns/1ps
module apsl_ctrl_tb;
    localparam int HI = 4;
    localparam int SL = 20;
    localparam logic [7:0] fzColdTbl [4] = '{8'h04, 8'h06, 8'h08, 8'h0a};
    localparam logic [7:0] frColdTbl [4] = '{8'h08, 8'h06, 8'h0a, 8'h04};
    localparam logic [7:0] fzWarmTbl [4] = '{8'h08, 8'h04, 8'h06, 8'h0a};
    localparam logic [7:0] ambTbl    [4] = '{8'hff, 8'hfe, 8'h01, 8'h00};
    logic mclk, rst, hsel, hwrite, hreadyout, hresp, fzDoor, frDoor;
    logic fzFan, frFan, fzDef, frDef, comp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, keySense;
    logic [39:0] strap;
    logic [4:0]  phase;
    logic [9:0]  pressMask;
    logic [7:0]  fz, fr, cmp;
    int          nMismatch, totalChecks;
    apsl_ctrl #(.PHASE_HIGH_CYC(HI), .PHASE_SLOT_CYC(SL)) apsl_ctrl_inst (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .keySense(keySense), .strap(strap), .freezerDoorContact(fzDoor), .fridgeDoorContact(frDoor),
        .scanPhaseLine(phase), .compDrive(comp), .freezerDefrostDrive(fzDef), .fridgeDefrostDrive(frDef),
        .freezerFanDrive(fzFan), .fridgeFanDrive(frFan));
    apsl_panel_model apsl_panel_model_inst (.phaseLine(phase), .pressMask(pressMask), .keySense(keySense));
    always #2.5 mclk = ~mclk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    // one single transfer; the second wait is the data phase, read data is taken at its closing edge
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= {27'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask : wr
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rdChk(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0000_0000, x);
        chk(nm, exp, x & m);
    endtask : rdChk
    task automatic doReset();
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask : doReset
    initial begin
        #100000;
        nMismatch++;
        $display("[ERR] watchdog expired before the tests ended");
        final_report();
    end
    initial begin
        mclk = 0; rst = 1; hsel = 0; hwrite = 0; htrans = 0; haddr = 0; hwdata = 0;
        strap = 0; fzDoor = 1; frDoor = 1; pressMask = 0;
        for (int i = 0; i < 16; i++) begin
            strap <= {{25{i[0]}}, i[1:0], i[1:0], i[1:0], i[1:0], i[3], i[2:0], i[2:0]};
            doReset();
            fz = 8'h00 - 8'(i[2:0]);
            fr = i[3] ? 8'(i[2:0]) + 8'h01 : 8'h00 - 8'(i[2:0]);
            cmp = ambTbl[i[1:0]];
            rdChk("loads", 5'h00, 32'hffff_ffff, 32'h0000_0000);
            rdChk("optlo", 5'h0c, 32'hffff_ffff, strap[31:0]);
            rdChk("opthi", 5'h10, 32'hffff_ffff, {24'h0, strap[39:32]});
            rdChk("decode1", 5'h18, 32'hffff_ffff, {8'h00, fzWarmTbl[i[1:0]], frColdTbl[i[1:0]], fzColdTbl[i[1:0]]});
            rdChk("decode0", 5'h14, 32'hffff_ffff, {16'h0, fr, fz});
            wr(5'h00, 32'h0000_0020);
            rdChk("decode0amb", 5'h14, 32'hffff_ffff, {8'h00, cmp, fr + cmp, fz + cmp});
            strap <= ~strap;
            repeat (6) @(posedge mclk);
            rdChk("optlo held", 5'h0c, 32'hffff_ffff, ~strap[31:0]);
        end
        rdChk("unmapped", 5'h1c, 32'hffff_ffff, 32'h0000_0000);
        for (int c = 0; c < 32; c++) begin
            wr(5'h00, c);
            repeat (4) @(posedge mclk);
            chk("loads", {c[4], c[3], c[2] & ~c[0], c[1] & ~c[0], c[0]}, {frFan, fzFan, frDef, fzDef, comp});
        end
        fzDoor <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("fans", 32'h0000_0010, {fzFan, frFan, 4'h0});
        frDoor <= 1'b0;
        repeat (8) @(posedge mclk);
        rdChk("status", 5'h04, 32'h0000_007f, 32'h0000_0001);
        wr(5'h00, 32'h0000_0000);
        rdChk("fzset", 5'h04, 32'h0000_7000, 32'h0000_2000);
        pressMask <= 10'h009;
        repeat (6 * SL) @(posedge mclk);
        pressMask <= 10'h000;
        repeat (SL) @(posedge mclk);
        rdChk("keyevt", 5'h08, 32'hffff_ffff, 32'h0000_0009);
        rdChk("fzset", 5'h04, 32'h0000_7000, 32'h0000_3000);
        wr(5'h08, 32'h0000_03ff);
        rdChk("keyclr", 5'h08, 32'hffff_ffff, 32'h0000_0000);
        final_report();
    end
endmodule : apsl_ctrl_tb
